/* pod_pkg.sv */
// Purpose: constants for the pwm output disable block
// Assumes: one 20 MHz clock, which also serves as the peripheral clock
// Notes: sample counts are cycle counts at that clock; the pwm period and dead time are given in ns and converted to cycles
`default_nettype none

package pod_pkg;
	// =====================================================
	// fault input detection modes
	typedef enum logic {
		POD_MODE_FALL,
		POD_MODE_LOW
	} pod_mode_t;

	// =====================================================
	// timing
	localparam int POD_CLK_HZ = 20000000;
	localparam int POD_LOW_SAMPLES = 3;
	localparam int POD_PWM_PERIOD_NS = 100000;
	localparam int POD_DEAD_TIME_NS = 2000;
	localparam int POD_CLK_NS = 1000000000 / POD_CLK_HZ;
	localparam int POD_PWM_PERIOD_CYC = POD_PWM_PERIOD_NS / POD_CLK_NS;
	localparam int POD_DEAD_CYC = (POD_DEAD_TIME_NS + POD_CLK_NS - 1) / POD_CLK_NS;
	localparam int POD_HALF_CYC = POD_PWM_PERIOD_CYC / 2;

	// =====================================================
	// reset values
	localparam logic POD_FLAG_RST = 1'b0;
	localparam logic [2:0] POD_SYNC_RST = 3'h7;
endpackage : pod_pkg

`default_nettype wire

/* pod_output_disable.sv */
// Purpose: forces six complementary pwm pins to high impedance on fault
// Assumes: fault pins are asynchronous and are synchronised here
// Notes: output enables are active low; a high enable means the pin floats
`default_nettype none

module pod_output_disable #(
	parameter int LOW_SAMPLES = pod_pkg::POD_LOW_SAMPLES
) (
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire logic fault_input_a_n_i,
	input wire logic fault_input_b_n_i,
	input wire logic fault_a_low_mode_i,
	input wire logic fault_b_low_mode_i,
	input wire logic fault_a_clear_i,
	input wire logic fault_b_clear_i,
	input wire logic software_hiz_bit_i,
	input wire logic osc_stop_i,
	input wire logic pwm_run_i,
	output logic fault_a_request_flag_o,
	output logic fault_b_request_flag_o,
	output logic osc_stop_flag_o,
	output logic output_enable_irq_a_o,
	output logic output_enable_irq_b_o,
	output logic fault_a_level_o,
	output logic fault_b_level_o,
	output logic hiz_active_o,
	output logic [2:0] pwm_out_o,
	output logic [2:0] pwm_out_neg_o,
	output logic [2:0] pwm_out_oe_n_o,
	output logic [2:0] pwm_out_neg_oe_n_o
);
	// =====================================================
	// state
	typedef struct packed {
		logic [1:0] sync1;
		logic [1:0] sync2;
		logic [1:0] prev;
		logic [1:0][7:0] low_cnt;
		logic flag_a;
		logic flag_b;
		logic osc_flag;
		logic [1:0] soft_sync;
		logic hiz;
		logic [15:0] pwm_cnt;
		logic [2:0] pwm_p;
		logic [2:0] pwm_n;
	} pod_state_t;

	pod_state_t st_r;
	pod_state_t st_nxt;

	localparam logic [15:0] HALF = 16'(pod_pkg::POD_HALF_CYC);
	localparam logic [15:0] PERIOD = 16'(pod_pkg::POD_PWM_PERIOD_CYC);
	localparam logic [15:0] DEAD = 16'(pod_pkg::POD_DEAD_CYC);
	localparam logic [7:0] SAMPLES = 8'(LOW_SAMPLES);

	// phase offsets of the three pairs, a third of a period apart
	function automatic logic [15:0] pod_phase(input logic [15:0] cnt, input logic [1:0] k);
		logic [16:0] s;
		s = {1'b0, cnt} + 17'(k) * 17'(PERIOD / 16'h0003);
		if (s >= {1'b0, PERIOD})
			s = s - {1'b0, PERIOD};
		return s[15:0];
	endfunction : pod_phase

	logic [1:0] fault_low;
	logic [1:0] low_mode;
	logic [1:0] clr;
	logic [1:0] hit;
	logic [15:0] ph;

	always_comb
	begin
		st_nxt = st_r;
		low_mode = {fault_b_low_mode_i, fault_a_low_mode_i};
		clr = {fault_b_clear_i, fault_a_clear_i};
		ph = 16'h0000;
		st_nxt.sync1 = {fault_input_b_n_i, fault_input_a_n_i};
		st_nxt.sync2 = st_r.sync1;
		st_nxt.prev = st_r.sync2;
		fault_low = ~st_r.sync2;
		for (int i = 0; i < 2; i++)
		begin
			// low-level mode counts consecutive low samples, one per clock
			if (fault_low[i] && st_r.low_cnt[i] != SAMPLES)
				st_nxt.low_cnt[i] = st_r.low_cnt[i] + 8'h01;
			else if (!fault_low[i])
				st_nxt.low_cnt[i] = 8'h00;
			// edge mode fires only on a new high-to-low transition
			hit[i] = low_mode[i] ? (fault_low[i] && st_r.low_cnt[i] == SAMPLES - 8'h01)
				: (st_r.prev[i] && !st_r.sync2[i]);
		end
		// set wins over a clear in the same cycle
		st_nxt.flag_a = hit[0] | (st_r.flag_a & ~clr[0]);
		st_nxt.flag_b = hit[1] | (st_r.flag_b & ~clr[1]);
		// no clear path: only reset drops it
		st_nxt.osc_flag = st_r.osc_flag | osc_stop_i;
		st_nxt.soft_sync = {st_r.soft_sync[0], software_hiz_bit_i};
		// edge reaches hiz three clocks after the pin falls, inside 7.5
		// only the second soft flop is read, so a metastable first stage never reaches hiz
		st_nxt.hiz = st_nxt.flag_a | st_nxt.flag_b | st_nxt.osc_flag
			| st_r.soft_sync[1];
		// free-running complementary pwm with dead time
		if (!pwm_run_i)
			st_nxt.pwm_cnt = 16'h0000;
		else if (st_r.pwm_cnt == PERIOD - 16'h0001)
			st_nxt.pwm_cnt = 16'h0000;
		else
			st_nxt.pwm_cnt = st_r.pwm_cnt + 16'h0001;
		for (int k = 0; k < 3; k++)
		begin
			ph = pod_phase(st_r.pwm_cnt, 2'(k));
			st_nxt.pwm_p[k] = pwm_run_i && ph >= DEAD && ph < HALF;
			st_nxt.pwm_n[k] = pwm_run_i && ph >= HALF + DEAD;
		end
	end

	always_ff @(posedge ref_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			st_r <= '0;
			st_r.sync1 <= pod_pkg::POD_SYNC_RST[1:0];
			st_r.sync2 <= pod_pkg::POD_SYNC_RST[1:0];
			st_r.prev <= pod_pkg::POD_SYNC_RST[1:0];
			st_r.flag_a <= pod_pkg::POD_FLAG_RST;
			st_r.flag_b <= pod_pkg::POD_FLAG_RST;
			st_r.osc_flag <= pod_pkg::POD_FLAG_RST;
		end
		else
			st_r <= st_nxt;
	end

	// =====================================================
	// outputs
	assign fault_a_request_flag_o = st_r.flag_a;
	assign fault_b_request_flag_o = st_r.flag_b;
	assign osc_stop_flag_o = st_r.osc_flag;
	assign output_enable_irq_a_o = st_r.flag_a;
	assign output_enable_irq_b_o = st_r.flag_b;
	// synchronised pin levels let software wait for a high fault pin before restore
	assign fault_a_level_o = st_r.sync2[0];
	assign fault_b_level_o = st_r.sync2[1];
	assign hiz_active_o = st_r.hiz;
	assign pwm_out_o = st_r.pwm_p;
	assign pwm_out_neg_o = st_r.pwm_n;
	assign pwm_out_oe_n_o = {3{st_r.hiz}};
	assign pwm_out_neg_oe_n_o = {3{st_r.hiz}};
endmodule : pod_output_disable

`default_nettype wire

/* pod_chk.sv */
// Purpose: port checks. Assumes: bound to pod_output_disable. Notes: latency bound is edge mode
`default_nettype none
module pod_chk (
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire logic fault_input_a_n_i,
	input wire logic fault_a_low_mode_i,
	input wire logic software_hiz_bit_i,
	input wire logic fault_a_request_flag_o,
	input wire logic osc_stop_flag_o,
	input wire logic output_enable_irq_a_o,
	input wire logic hiz_active_o,
	input wire logic [2:0] pwm_out_oe_n_o,
	input wire logic [2:0] pwm_out_neg_oe_n_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);
	wire logic fl_w = fault_a_request_flag_o;
	wire logic hz_w = hiz_active_o;
	wire logic any_w = fl_w | osc_stop_flag_o;
	sequence s_fall;
		$fell(fault_input_a_n_i) && !fault_a_low_mode_i;
	endsequence
	AST_OE: assert property ({pwm_out_oe_n_o, pwm_out_neg_oe_n_o} == {6{hz_w}})
		else $error("oe wrong");
	AST_FALL: assert property (s_fall |-> ##[1:7] fl_w) else $error("slow");
	AST_IRQ: assert property (output_enable_irq_a_o == fl_w) else $error("irq");
	AST_SOFT: assert property ($rose(software_hiz_bit_i) |-> ##[1:3] hz_w)
		else $error("sw slow");
	AST_SWHOLD: assert property (software_hiz_bit_i [*4] |-> hz_w) else $error("sw");
	AST_OSC: assert property (osc_stop_flag_o |=> osc_stop_flag_o) else $error("osc");
	AST_HOLD: assert property (any_w |-> hz_w) else $error("hold");
	AST_REL: assert property ($fell(hz_w) |-> !any_w) else $error("rel");
endmodule : pod_chk
bind pod_output_disable pod_chk i_chk (.*);
`default_nettype wire

/* pod_gate_model.sv */
// Purpose: gate drivers. Assumes: a floated pin shows its inverse. Notes: shoot is sticky
`default_nettype none
module pod_gate_model (
	input wire logic clk_i,
	input wire logic [5:0] drv_i,
	input wire logic [5:0] oe_n_i,
	output logic [5:0] pin_o,
	output logic shoot_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial pin_o = 6'h00;
	initial shoot_o = 1'b0;
	always @(posedge clk_i)
	begin
		pin_o <= (drv_i & ~oe_n_i) | (~pin_o & oe_n_i);
		if (|(drv_i[2:0] & drv_i[5:3] & ~oe_n_i[2:0]))
			shoot_o <= 1'b1;
	end
endmodule : pod_gate_model
`default_nettype wire

/* pod_output_disable_tb_top.sv */
// Purpose: bench. Assumes: inputs change at the falling edge. Notes: one step table
`default_nettype none
module pod_output_disable_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk_i = 0, reset_i = 1, ma = 0, fa = 1, fb = 1, sw = 0, osc = 0, clr = 0;
	wire logic fault_a_low_mode_i = ma, fault_b_low_mode_i = 1'b0, pwm_run_i = 1'b1;
	wire logic fault_input_a_n_i = fa, fault_input_b_n_i = fb, software_hiz_bit_i = sw;
	wire logic osc_stop_i = osc, fault_a_clear_i = clr, fault_b_clear_i = clr;
	wire logic fault_a_request_flag_o, fault_b_request_flag_o, osc_stop_flag_o, hiz_active_o;
	wire logic output_enable_irq_a_o, output_enable_irq_b_o, fault_a_level_o, fault_b_level_o;
	wire logic [2:0] pwm_out_o, pwm_out_neg_o, pwm_out_oe_n_o, pwm_out_neg_oe_n_o;
	wire logic shoot;
	wire logic [3:0] st = {fault_a_request_flag_o, fault_b_request_flag_o, osc_stop_flag_o,
		hiz_active_o};
	int fail_count = 0, n_compared = 0;
	// {ma fa fb sw osc clr, wait cycles, flags a b osc and hiz}
	logic [15:0] steps [19] = '{16'h1820, 16'h0849, 16'h0920, 16'h0840, 16'h1085, 16'h1435,
		16'h1521, 16'h1c31, 16'h1840, 16'h1c31, 16'h1840, 16'h2840, 16'h2839, 16'h3839,
		16'h3920, 16'h008d, 16'h0120, 16'h1a43, 16'h1923};
	pod_output_disable i_dut (.*);
	pod_gate_model i_gate (.clk_i(ref_clk_i), .drv_i({pwm_out_neg_o, pwm_out_o}),
		.oe_n_i({pwm_out_neg_oe_n_o, pwm_out_oe_n_o}), .pin_o(), .shoot_o(shoot));
	always #25 ref_clk_i = ~ref_clk_i;
	task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
		n_compared++;
		fail_count += int'(seen !== exp);
		if (seen !== exp)
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
	endtask : chk
	task automatic tally_and_finish();
		$display("compared %0d failed %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : tally_and_finish
	// =====================================================
	// watchdog: the steps need well under a thousand cycles
	initial
	begin
		#150000;
		fail_count++;
		tally_and_finish();
	end
	initial
	begin
		repeat (4) @(negedge ref_clk_i);
		chk(st, 4'h0);
		reset_i = 0;
		// one restore step raises the soft bit before clearing flag b with its pin low; the others clear with the soft bit off, the low-mode one with pin a high
		foreach (steps[i])
		begin
			{ma, fa, fb, sw, osc, clr} = steps[i][13:8];
			repeat (steps[i][7:4]) @(negedge ref_clk_i);
			chk(st, steps[i][3:0]);
			chk({output_enable_irq_a_o, output_enable_irq_b_o}, {2'h0, steps[i][3:2]});
			chk({fault_a_level_o, fault_b_level_o}, {2'h0, fa, fb});
			chk({pwm_out_oe_n_o[0], pwm_out_neg_oe_n_o[0]}, {2'h0, {2{steps[i][0]}}});
			chk({pwm_out_oe_n_o[2:1], pwm_out_neg_oe_n_o[2:1]}, {4{steps[i][0]}});
			chk({1'b0, pwm_out_o & pwm_out_neg_o}, 4'h0);
		end
		reset_i = 1;
		@(negedge ref_clk_i);
		reset_i = 0;
		@(negedge ref_clk_i);
		chk(st, 4'h0);
		chk({3'h0, shoot}, 4'h0);
		tally_and_finish();
	end
endmodule : pod_output_disable_tb_top
`default_nettype wire
